// ### rtl/sfr_indirect_addressing_core.sv
// sfr core: indirect ports, pointers, pcl jump, table read, status guard
// Summary of operation
// RL1: indirect port accesses go to the location held in its pointer.
// RL2: first port with its single pointer reaches sector zero only.
// RL3: ports two and three use pointer sector byte plus low byte.
// RL4: port read as itself returns zero; write to it does nothing.
// RL5: five pointer bytes are real read-write registers.
// RL6: extended address splits into sector high part and location low byte.
// RL7: bank bit clear selects bank zero, set bank one; resets to zero.
// RL8: bank register bits seven to one always read zero.
// RL9: code sets bank bit before jump or call.
// RL10: writing pcl jumps within current page, low eight bits only.
// RL11: a pcl jump inserts one dummy instruction cycle.
// RL12: table read fetches word at pointers; high byte to table-high.
// RL13: code loads both table pointers before a table read.
// RL14: status arithmetic flags alter like ordinary register bits.
// RL15: writes to status never change timeout or power-down flags.
// RL16: timeout flag moves only on reset, timeout, clear or halt.
// RL17: power-down flag moves only on halt, clear or reset.
// RL18: no register-to-register move; accumulator carries transfers.
// RL19: timeout cleared by reset, clear and halt; set by timeout.
// RL20: power-down cleared by reset and clear; set by halt.
// RL21: unused special locations read as zero.
// RL22: low pointer increment wraps in eight bits, no carry to sector.
`timescale 1ns/10ps
module sfr_indirect_addressing_core
  import sfr_core_pkg::*;
#(
  parameter int DMEM_SECTORS = 8 // data memory sectors of 256 bytes
) (
  input wire logic clk_in, // instruction clock
  input wire logic nrst_in, // async reset, active low
  input wire mem_req_t req_in, // data memory access
  output logic [7:0] rd_data_out, // read data, one cycle after request
  output logic rd_valid_out, // read data strobe
  input wire logic [7:0] pc_low_in, // current program counter low byte
  output logic jump_out, // pcl write jump strobe
  output logic [7:0] jump_low_out, // new program counter low byte
  output logic dummy_cycle_out, // cpu holds issue during this cycle
  output logic bank_select_out, // program memory bank
  input wire logic acc_we_in, // alu result into accumulator
  input wire logic [7:0] acc_wdata_in, // alu result
  output logic [7:0] acc_out, // accumulator
  input wire logic flags_we_in, // alu flag update
  input wire logic [7:0] flags_in, // alu flags in status layout
  input wire logic wdt_timeout_in, // watchdog time-out event
  input wire logic watchdog_clear_instr_in, // watchdog clear instruction executes
  input wire logic halt_in, // halt instruction executes
  output logic [7:0] status_out, // status register
  input wire logic tbl_read_in, // table read instruction starts
  output logic tbl_req_out, // program memory fetch request
  output logic [15:0] tbl_addr_out, // program word address
  input wire logic [15:0] tbl_word_in, // fetched program word
  input wire logic tbl_ack_in, // fetched word valid
  output logic [7:0] tbl_low_out, // low byte for the destination
  output logic tbl_low_valid_out // low byte strobe
);

  localparam int DMEM_DEPTH = DMEM_SECTORS * 256;

  // general purpose and sector ram, no reset: contents power up unknown
  logic [7:0] dmem [DMEM_DEPTH];

  logic [7:0] ptr0_q, ptr0_d;
  logic [7:0] ptr1l_q, ptr1l_d, ptr1h_q, ptr1h_d;
  logic [7:0] ptr2l_q, ptr2l_d, ptr2h_q, ptr2h_d;
  logic [7:0] acc_q, acc_d;
  logic [7:0] table_pointer_low_q, table_pointer_low_d, table_pointer_high_q, table_pointer_high_d, table_data_high_q, table_data_high_d;
  logic [7:0] status_q, status_d;
  logic bank_q, bank_d;
  logic [7:0] rd_data_q, rd_data_d;
  logic rd_valid_q, rd_valid_d;
  logic jump_q, jump_d;
  logic [7:0] jump_low_q, jump_low_d;
  logic dummy_q, dummy_d;
  tbl_state_t tbl_state_q, tbl_state_d;
  logic tbl_req_q, tbl_req_d;
  logic [15:0] tbl_addr_q, tbl_addr_d;
  logic [7:0] tbl_low_q, tbl_low_d;
  logic tbl_low_valid_q, tbl_low_valid_d;

  logic [DADDR_W-1:0] eff_addr;
  logic eff_special, eff_port, eff_ram;
  logic [7:0] eff_low;

  // resolve the target: ports redirect through their pointers
  always_comb begin
    eff_addr = req_in.addr; // RL6
    if (req_in.addr[DADDR_W-1:8] == '0) begin
      unique case (req_in.addr[7:0])
        OFS_INDIRECT_PORT_SECTOR0: eff_addr = {{SECTOR_W{1'b0}}, ptr0_q}; // RL1 RL2
        OFS_INDIRECT_PORT_ONE: eff_addr = {ptr1h_q[SECTOR_W-1:0], ptr1l_q}; // RL1 RL3
        OFS_INDIRECT_PORT_TWO: eff_addr = {ptr2h_q[SECTOR_W-1:0], ptr2l_q}; // RL1 RL3
        default: eff_addr = req_in.addr;
      endcase
    end
    eff_low = eff_addr[7:0];
    eff_special = (eff_addr[DADDR_W-1:8] <= SPECIAL_LAST_SECTOR) &&
                  (eff_low < GP_BASE);
    // a pointer aimed at a port finds no storage there
    eff_port = (eff_addr[DADDR_W-1:8] == '0) &&
               (eff_low == OFS_INDIRECT_PORT_SECTOR0 ||
                eff_low == OFS_INDIRECT_PORT_ONE ||
                eff_low == OFS_INDIRECT_PORT_TWO); // RL4
    eff_ram = !eff_special &&
              (int'(eff_addr[DADDR_W-1:8]) < DMEM_SECTORS);
  end

  // read mux of special registers; unused and port locations give zero
  function automatic logic [7:0] sfr_read(input logic [DADDR_W-1:0] a,
                                          input logic [7:0] program_counter_low);
    logic [7:0] v;
    v = UNUSED_READ; // RL21 RL4
    if (a[DADDR_W-1:8] == '0) begin
      unique case (a[7:0])
        OFS_POINTER_SECTOR0: v = ptr0_q; // RL5
        OFS_POINTER_ONE_LOW: v = ptr1l_q;
        OFS_POINTER_ONE_SECTOR: v = ptr1h_q;
        OFS_POINTER_TWO_LOW: v = ptr2l_q;
        OFS_POINTER_TWO_SECTOR: v = ptr2h_q;
        OFS_ACCUMULATOR: v = acc_q;
        OFS_PROGRAM_COUNTER_LOW: v = program_counter_low;
        OFS_TABLE_POINTER_LOW: v = table_pointer_low_q;
        OFS_TABLE_POINTER_HIGH: v = table_pointer_high_q;
        OFS_TABLE_DATA_HIGH: v = table_data_high_q;
        OFS_STATUS: v = status_q;
        OFS_PROGRAM_BANK_SELECT: v = {7'h00, bank_q}; // RL8
        default: v = UNUSED_READ;
      endcase
    end
    return v;
  endfunction

  logic wr_sfr;
  assign wr_sfr = req_in.valid && req_in.write && eff_special &&
                  !eff_port && (eff_addr[DADDR_W-1:8] == '0);

  // next values of the register file and the status flags
  always_comb begin
    ptr0_d = ptr0_q;
    ptr1l_d = ptr1l_q;
    ptr1h_d = ptr1h_q;
    ptr2l_d = ptr2l_q;
    ptr2h_d = ptr2h_q;
    acc_d = acc_q;
    table_pointer_low_d = table_pointer_low_q;
    table_pointer_high_d = table_pointer_high_q;
    bank_d = bank_q;
    status_d = status_q;
    jump_d = 1'b0;
    jump_low_d = jump_low_q;
    // ram data reaches another register only through the accumulator
    if (acc_we_in) begin
      acc_d = acc_wdata_in; // RL18
    end
    if (flags_we_in) begin
      status_d = (flags_in & ~ST_PROTECT_MASK) |
                 (status_q & ST_PROTECT_MASK); // RL14 RL15
    end
    if (wr_sfr) begin
      unique case (eff_low)
        // byte-wide stores: an increment wraps, sector byte untouched
        OFS_POINTER_SECTOR0: ptr0_d = req_in.wdata; // RL5 RL22
        OFS_POINTER_ONE_LOW: ptr1l_d = req_in.wdata; // RL5 RL22
        OFS_POINTER_ONE_SECTOR: ptr1h_d = req_in.wdata; // RL5
        OFS_POINTER_TWO_LOW: ptr2l_d = req_in.wdata; // RL5 RL22
        OFS_POINTER_TWO_SECTOR: ptr2h_d = req_in.wdata; // RL5
        OFS_ACCUMULATOR: acc_d = req_in.wdata;
        OFS_PROGRAM_COUNTER_LOW: begin
          jump_d = 1'b1; // RL10
          jump_low_d = req_in.wdata; // RL10
        end
        OFS_TABLE_POINTER_LOW: table_pointer_low_d = req_in.wdata;
        OFS_TABLE_POINTER_HIGH: table_pointer_high_d = req_in.wdata;
        OFS_STATUS: begin
          status_d = (req_in.wdata & ~ST_PROTECT_MASK) |
                     (status_q & ST_PROTECT_MASK); // RL14 RL15
        end
        OFS_PROGRAM_BANK_SELECT: bank_d = req_in.wdata[0]; // RL7 RL8
        default: ;
      endcase
    end
    // system flags: only halt, clear and timeout move them; set wins
    if (watchdog_clear_instr_in || halt_in) begin
      status_d[ST_TIMEOUT_BIT] = 1'b0; // RL16 RL19
    end
    if (wdt_timeout_in) begin
      status_d[ST_TIMEOUT_BIT] = 1'b1; // RL16 RL19
    end
    if (watchdog_clear_instr_in) begin
      status_d[ST_POWER_DOWN_BIT] = 1'b0; // RL17 RL20
    end
    if (halt_in) begin
      status_d[ST_POWER_DOWN_BIT] = 1'b1; // RL17 RL20
    end
  end

  // read answer and the dummy cycle after a pcl jump
  always_comb begin
    rd_valid_d = req_in.valid && !req_in.write;
    rd_data_d = UNUSED_READ;
    if (req_in.valid && !req_in.write) begin
      if (eff_special) begin
        rd_data_d = sfr_read(eff_addr, pc_low_in); // RL4 RL21
      end else if (eff_ram) begin
        rd_data_d = dmem[eff_addr];
      end
    end
    dummy_d = jump_q; // RL11
  end

  // table read: request stands until the program word is acknowledged
  always_comb begin
    tbl_state_d = tbl_state_q;
    tbl_req_d = tbl_req_q;
    tbl_addr_d = tbl_addr_q;
    table_data_high_d = table_data_high_q;
    tbl_low_d = tbl_low_q;
    tbl_low_valid_d = 1'b0;
    if (wr_sfr && eff_low == OFS_TABLE_DATA_HIGH) begin
      table_data_high_d = req_in.wdata;
    end
    unique case (tbl_state_q)
      TBL_IDLE: begin
        if (tbl_read_in) begin
          tbl_req_d = 1'b1;
          tbl_addr_d = {table_pointer_high_q, table_pointer_low_q}; // RL12
          tbl_state_d = TBL_WAIT;
        end
      end
      TBL_WAIT: begin
        if (tbl_ack_in) begin
          tbl_req_d = 1'b0;
          table_data_high_d = tbl_word_in[15:8]; // RL12
          tbl_low_d = tbl_word_in[7:0]; // RL12
          tbl_low_valid_d = 1'b1;
          tbl_state_d = TBL_IDLE;
        end
      end
    endcase
  end

  // register stage for every piece of control state
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ptr0_q <= RST_BYTE;
      ptr1l_q <= RST_BYTE;
      ptr1h_q <= RST_BYTE;
      ptr2l_q <= RST_BYTE;
      ptr2h_q <= RST_BYTE;
      acc_q <= RST_BYTE;
      table_pointer_low_q <= RST_BYTE;
      table_pointer_high_q <= RST_BYTE;
      table_data_high_q <= RST_BYTE;
      status_q <= RST_BYTE; // RL19 RL20
      bank_q <= 1'b0; // RL7
      rd_data_q <= RST_BYTE;
      rd_valid_q <= 1'b0;
      jump_q <= 1'b0;
      jump_low_q <= RST_BYTE;
      dummy_q <= 1'b0;
      tbl_state_q <= TBL_IDLE;
      tbl_req_q <= 1'b0;
      tbl_addr_q <= 16'h0000;
      tbl_low_q <= RST_BYTE;
      tbl_low_valid_q <= 1'b0;
    end else begin
      ptr0_q <= ptr0_d;
      ptr1l_q <= ptr1l_d;
      ptr1h_q <= ptr1h_d;
      ptr2l_q <= ptr2l_d;
      ptr2h_q <= ptr2h_d;
      acc_q <= acc_d;
      table_pointer_low_q <= table_pointer_low_d;
      table_pointer_high_q <= table_pointer_high_d;
      table_data_high_q <= table_data_high_d;
      status_q <= status_d;
      bank_q <= bank_d;
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
      jump_q <= jump_d;
      jump_low_q <= jump_low_d;
      dummy_q <= dummy_d;
      tbl_state_q <= tbl_state_d;
      tbl_req_q <= tbl_req_d;
      tbl_addr_q <= tbl_addr_d;
      tbl_low_q <= tbl_low_d;
      tbl_low_valid_q <= tbl_low_valid_d;
    end
  end

  // ram write; ports and special space never land here
  always_ff @(posedge clk_in) begin
    if (req_in.valid && req_in.write && eff_ram) begin
      dmem[eff_addr] <= req_in.wdata; // RL1 RL3
    end
  end

  assign rd_data_out = rd_data_q;
  assign rd_valid_out = rd_valid_q;
  assign jump_out = jump_q;
  assign jump_low_out = jump_low_q;
  assign dummy_cycle_out = dummy_q;
  assign bank_select_out = bank_q;
  assign acc_out = acc_q;
  assign status_out = status_q;
  assign tbl_req_out = tbl_req_q;
  assign tbl_addr_out = tbl_addr_q;
  assign tbl_low_out = tbl_low_q;
  assign tbl_low_valid_out = tbl_low_valid_q;

  a_port_reads_zero: assert property ( // RL4
    @(posedge clk_in) disable iff (!nrst_in)
    (req_in.valid && !req_in.write && eff_port) |=> rd_data_out == 8'h00
  ) else $error("port read did not return zero");

  a_sector0_only: assert property ( // RL2
    @(posedge clk_in) disable iff (!nrst_in)
    (req_in.addr == {{SECTOR_W{1'b0}}, OFS_INDIRECT_PORT_SECTOR0}) |->
      eff_addr[DADDR_W-1:8] == '0
  ) else $error("first port left sector zero");

  a_port_one_sector: assert property ( // RL1 RL3
    @(posedge clk_in) disable iff (!nrst_in)
    (req_in.addr == {{SECTOR_W{1'b0}}, OFS_INDIRECT_PORT_ONE}) |->
      eff_addr == {ptr1h_q[SECTOR_W-1:0], ptr1l_q}
  ) else $error("second port target wrong");

  a_status_guard: assert property ( // RL15 RL16 RL17
    @(posedge clk_in) disable iff (!nrst_in)
    (!watchdog_clear_instr_in && !halt_in && !wdt_timeout_in) |=>
      $stable(status_out[5:4])
  ) else $error("system flag moved without cause");

  a_halt_flags: assert property ( // RL19 RL20
    @(posedge clk_in) disable iff (!nrst_in)
    (halt_in && !wdt_timeout_in) |=> status_out[5:4] == 2'b01
  ) else $error("halt did not set power-down, clear timeout");

  a_timeout_sets: assert property ( // RL19
    @(posedge clk_in) disable iff (!nrst_in)
    wdt_timeout_in |=> status_out[ST_TIMEOUT_BIT]
  ) else $error("timeout flag not set");

  a_pcl_jump: assert property ( // RL10 RL11
    @(posedge clk_in) disable iff (!nrst_in)
    (wr_sfr && eff_low == OFS_PROGRAM_COUNTER_LOW) |=>
      jump_out && jump_low_out == $past(req_in.wdata) ##1
      dummy_cycle_out ##1 !dummy_cycle_out || jump_out
  ) else $error("pcl jump or dummy cycle wrong");

  a_table_latch: assert property ( // RL12
    @(posedge clk_in) disable iff (!nrst_in)
    (tbl_state_q == TBL_WAIT && tbl_ack_in) |=>
      tbl_low_valid_out && tbl_low_out == $past(tbl_word_in[7:0]) &&
      rd_valid_out == $past(req_in.valid && !req_in.write)
  ) else $error("table word not delivered");

  a_bank_bits: assert property ( // RL7 RL8
    @(posedge clk_in) disable iff (!nrst_in)
    (req_in.valid && !req_in.write &&
     req_in.addr == {{SECTOR_W{1'b0}}, OFS_PROGRAM_BANK_SELECT}) |=>
      rd_data_out == {7'h00, bank_select_out}
  ) else $error("bank register upper bits not zero");

endmodule

// ### shared/sfr_core_pkg.sv
// package: offsets, layouts and reset values for the sfr indirect core
package sfr_core_pkg;
  localparam int SECTOR_W = 3; // sector select bits kept
  localparam int DADDR_W = SECTOR_W + 8; // extended data address width
  // sector 0 special register offsets
  localparam logic [7:0] OFS_INDIRECT_PORT_SECTOR0 = 8'h00;
  localparam logic [7:0] OFS_POINTER_SECTOR0 = 8'h01;
  localparam logic [7:0] OFS_INDIRECT_PORT_ONE = 8'h02;
  localparam logic [7:0] OFS_POINTER_ONE_LOW = 8'h03;
  localparam logic [7:0] OFS_POINTER_ONE_SECTOR = 8'h04;
  localparam logic [7:0] OFS_ACCUMULATOR = 8'h05;
  localparam logic [7:0] OFS_PROGRAM_COUNTER_LOW = 8'h06;
  localparam logic [7:0] OFS_TABLE_POINTER_LOW = 8'h07;
  localparam logic [7:0] OFS_TABLE_DATA_HIGH = 8'h08;
  localparam logic [7:0] OFS_TABLE_POINTER_HIGH = 8'h09;
  localparam logic [7:0] OFS_STATUS = 8'h0a;
  localparam logic [7:0] OFS_PROGRAM_BANK_SELECT = 8'h0b;
  localparam logic [7:0] OFS_INDIRECT_PORT_TWO = 8'h0c;
  localparam logic [7:0] OFS_POINTER_TWO_LOW = 8'h0d;
  localparam logic [7:0] OFS_POINTER_TWO_SECTOR = 8'h0e;
  localparam logic [7:0] GP_BASE = 8'h80; // first general purpose byte
  localparam logic [SECTOR_W-1:0] SPECIAL_LAST_SECTOR = 3'h1;
  // status register bit positions
  localparam int ST_TIMEOUT_BIT = 5;
  localparam int ST_POWER_DOWN_BIT = 4;
  localparam logic [7:0] ST_PROTECT_MASK = 8'h30; // bits no write touches
  localparam logic [7:0] BANK_SELECT_MASK = 8'h01; // only bit 0 exists
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] UNUSED_READ = 8'h00; // unused and port reads
  localparam int DUMMY_CYCLES = 1; // cycles inserted after a pcl jump

  // one data memory access from the cpu, valid for a single cycle
  typedef struct packed {
    logic valid;
    logic write;
    logic [DADDR_W-1:0] addr; // {sector, location}
    logic [7:0] wdata;
  } mem_req_t;

  // table read states, gray along idle -> wait
  typedef enum logic [0:0] {
    TBL_IDLE = 1'b0,
    TBL_WAIT = 1'b1
  } tbl_state_t;
endpackage

// ### sim/prog_mem_model.sv
// program memory model answering the core's table read fetches
`timescale 1ns/10ps
module prog_mem_model (
  input wire logic clk_in, // instruction clock
  input wire logic nrst_in, // async reset, active low
  input wire logic req_in, // fetch request from the core
  input wire logic [15:0] addr_in, // program word address
  input wire logic slow_in, // stretch the answer by three cycles
  output logic [15:0] word_out, // program word
  output logic ack_out // word strobe, one cycle
);
  logic [1:0] wait_q;
  // outside the ack cycle the word toggles so stale data never matches
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ack_out <= 1'b0;
      wait_q <= 2'h0;
      word_out <= 16'h0000;
    end else if (req_in && !ack_out && (!slow_in || wait_q == 2'h3)) begin
      ack_out <= 1'b1;
      wait_q <= 2'h0;
      word_out <= {addr_in[7:0] ^ 8'h3c, addr_in[15:8] + 8'h11};
    end else begin
      ack_out <= 1'b0;
      word_out <= ~word_out;
      if (req_in && !ack_out) wait_q <= wait_q + 2'h1;
    end
  end
endmodule

// ### sim/tb_top.sv
// self-checking bench for the sfr indirect addressing core
`timescale 1ns/10ps
module tb_top;
  import sfr_core_pkg::*;
  logic clk_in, nrst_in, acc_we, flags_we, wdt_to, watchdog_clear_instr, halt, tbl_rd;
  logic slow, rd_valid, jump, dummy, bank, tbl_req, tbl_ack, tbl_low_valid;
  logic [7:0] pc_low, acc_wdata, flags, rd_data, acc_o, status_o, tbl_low;
  logic [7:0] jump_low, st_m, loc, d, d1, d2, tl, th;
  logic [15:0] tbl_addr, tbl_word;
  logic [2:0] sec;
  logic [7:0] ptr_ofs [5] = '{OFS_POINTER_SECTOR0, OFS_POINTER_ONE_LOW,
    OFS_POINTER_ONE_SECTOR, OFS_POINTER_TWO_LOW, OFS_POINTER_TWO_SECTOR};
  mem_req_t req;
  int error_cnt, num_checks, cyc, k;

  sfr_indirect_addressing_core dut (.clk_in(clk_in), .nrst_in(nrst_in),
    .req_in(req), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
    .pc_low_in(pc_low), .jump_out(jump), .jump_low_out(jump_low),
    .dummy_cycle_out(dummy), .bank_select_out(bank), .acc_we_in(acc_we),
    .acc_wdata_in(acc_wdata), .acc_out(acc_o), .flags_we_in(flags_we),
    .flags_in(flags), .wdt_timeout_in(wdt_to), .watchdog_clear_instr_in(watchdog_clear_instr),
    .halt_in(halt), .status_out(status_o), .tbl_read_in(tbl_rd),
    .tbl_req_out(tbl_req), .tbl_addr_out(tbl_addr), .tbl_word_in(tbl_word),
    .tbl_ack_in(tbl_ack), .tbl_low_out(tbl_low),
    .tbl_low_valid_out(tbl_low_valid));
  prog_mem_model pm (.clk_in(clk_in), .nrst_in(nrst_in), .req_in(tbl_req),
    .addr_in(tbl_addr), .slow_in(slow), .word_out(tbl_word),
    .ack_out(tbl_ack));

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("wrong value run_length expected done seen hang");
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // every driver assigns once just after an edge, then lets one edge pass
  task automatic drive(input logic v, input logic w, input logic [2:0] s,
                       input logic [7:0] a, input logic [7:0] wd);
    req = '{v, w, {s, a}, wd};
    @(posedge clk_in);
    #1;
  endtask

  task automatic wr(input logic [2:0] s, input logic [7:0] a,
                    input logic [7:0] wd);
    drive(1'b1, 1'b1, s, a, wd);
  endtask

  task automatic rd(input logic [2:0] s, input logic [7:0] a,
                    input logic [7:0] exp, input string what);
    drive(1'b1, 1'b0, s, a, 8'h00);
    chk("rd_valid", 16'h0001, {15'h0, rd_valid});
    chk(what, {8'h00, exp}, {8'h00, rd_data});
  endtask

  task automatic idle();
    drive(1'b0, 1'b0, 3'h0, 8'h00, 8'h00);
  endtask

  // k: 0 bus write, 1 alu flags, 2 halt, 3 clear, 4 timeout, 5 halt+timeout
  task automatic st_step(input int kk, input logic [7:0] v);
    flags_we = (kk == 1);
    flags = v;
    halt = (kk == 2 || kk == 5);
    watchdog_clear_instr = (kk == 3);
    wdt_to = (kk == 4 || kk == 5);
    drive(kk == 0, 1'b1, 3'h0, OFS_STATUS, v);
  endtask

  // a timeout in the same cycle as a halt still sets the flag
  function automatic logic [7:0] st_next(logic [7:0] m, int kk,
                                          logic [7:0] v);
    if (kk <= 1) m = (v & ~ST_PROTECT_MASK) | (m & ST_PROTECT_MASK);
    if (kk == 2 || kk == 5) m[5:4] = 2'b01;
    if (kk == 3) m[5:4] = 2'b00;
    if (kk == 4 || kk == 5) m[5] = 1'b1;
    return m;
  endfunction

  initial begin
    nrst_in = 1'b0;
    req = '0;
    {acc_we, flags_we, wdt_to, watchdog_clear_instr, halt, tbl_rd, slow} = 7'h00;
    {pc_low, acc_wdata, flags} = 24'h000000;
    error_cnt = 0;
    num_checks = 0;
    cyc = 0;
    d = 8'($urandom(44688));
    repeat (4) @(posedge clk_in);
    #1 nrst_in = 1'b1;
    chk("status", 16'h0000, {8'h00, status_o});
    chk("bank", 16'h0000, {15'h0, bank});
    rd(3'h0, OFS_PROGRAM_BANK_SELECT, 8'h00, "bank_reg");
    wr(3'h0, OFS_PROGRAM_BANK_SELECT, 8'hff);
    rd(3'h0, OFS_PROGRAM_BANK_SELECT, 8'h01, "bank_reg");
    chk("bank", 16'h0001, {15'h0, bank});
    wr(3'h0, OFS_PROGRAM_BANK_SELECT, 8'h00);
    chk("bank", 16'h0000, {15'h0, bank});
    $display("test bank done");
    // sector bytes kept to the three bits the core uses for addressing
    for (int i = 0; i < 5; i++) begin
      d = 8'($urandom) & ((i == 2 || i == 4) ? 8'h07 : 8'hff);
      wr(3'h0, ptr_ofs[i], d);
      rd(3'h0, ptr_ofs[i], d, "pointer");
    end
    repeat (6) begin
      sec = 3'($urandom);
      loc = 8'h80 | 8'($urandom);
      d1 = 8'($urandom);
      d2 = 8'($urandom);
      wr(sec, loc, d1);
      wr(3'h0, OFS_POINTER_ONE_SECTOR, {5'h00, sec});
      wr(3'h0, OFS_POINTER_ONE_LOW, loc);
      rd(3'h0, OFS_INDIRECT_PORT_ONE, d1, "port_one");
      wr(3'h0, OFS_POINTER_TWO_SECTOR, {5'h00, sec});
      wr(3'h0, OFS_POINTER_TWO_LOW, loc);
      wr(3'h0, OFS_INDIRECT_PORT_TWO, d2);
      rd(sec, loc, d2, "direct");
    end
    wr(3'h0, loc, d1);
    wr(3'h1, loc, d2);
    wr(3'h0, OFS_POINTER_SECTOR0, loc);
    rd(3'h0, OFS_INDIRECT_PORT_SECTOR0, d1, "port_sector0");
    wr(3'h0, OFS_POINTER_TWO_SECTOR, 8'h00);
    wr(3'h0, OFS_POINTER_TWO_LOW, OFS_INDIRECT_PORT_TWO);
    wr(3'h0, OFS_INDIRECT_PORT_TWO, 8'h5a);
    rd(3'h0, OFS_INDIRECT_PORT_TWO, 8'h00, "port_self");
    rd(3'h0, 8'h6a, UNUSED_READ, "unused");
    rd(3'h1, 8'h7f, UNUSED_READ, "unused");
    $display("test indirect done");
    pc_low = 8'($urandom);
    d = 8'($urandom);
    wr(3'h0, OFS_PROGRAM_COUNTER_LOW, d);
    chk("jump", 16'h0001, {15'h0, jump});
    chk("jump_low", {8'h00, d}, {8'h00, jump_low});
    idle();
    chk("dummy", 16'h0001, {15'h0, dummy});
    chk("jump", 16'h0000, {15'h0, jump});
    rd(3'h0, OFS_PROGRAM_COUNTER_LOW, pc_low, "pcl");
    chk("dummy", 16'h0000, {15'h0, dummy});
    $display("test pcl done");
    acc_we = 1'b1;
    acc_wdata = d;
    wr(3'h0, OFS_ACCUMULATOR, d1);
    chk("acc", {8'h00, d1}, {8'h00, acc_o});
    acc_wdata = d2;
    idle();
    chk("acc", {8'h00, d2}, {8'h00, acc_o});
    acc_we = 1'b0;
    rd(3'h0, OFS_ACCUMULATOR, d2, "acc_reg");
    $display("test acc done");
    st_m = 8'h00;
    for (int i = 0; i < 24; i++) begin
      k = (i < 6) ? i : int'($urandom % 6);
      d = 8'($urandom);
      st_step(k, d);
      st_m = st_next(st_m, k, d);
      chk("status", {8'h00, st_m}, {8'h00, status_o});
    end
    st_step(6, 8'h00);
    rd(3'h0, OFS_STATUS, st_m, "status_reg");
    $display("test status done");
    for (int i = 0; i < 2; i++) begin
      tl = 8'($urandom);
      th = 8'($urandom);
      slow = 1'(i);
      wr(3'h0, OFS_TABLE_POINTER_LOW, tl);
      wr(3'h0, OFS_TABLE_POINTER_HIGH, th);
      tbl_rd = 1'b1;
      idle();
      tbl_rd = 1'b0;
      chk("tbl_req", 16'h0001, {15'h0, tbl_req});
      for (int n = 0; n < 20 && tbl_low_valid !== 1'b1; n++) begin
        @(posedge clk_in);
        #1;
      end
      chk("tbl_low_valid", 16'h0001, {15'h0, tbl_low_valid});
      chk("tbl_req", 16'h0000, {15'h0, tbl_req});
      chk("tbl_addr", {th, tl}, tbl_addr);
      chk("tbl_low", {8'h00, th + 8'h11}, {8'h00, tbl_low});
      rd(3'h0, OFS_TABLE_DATA_HIGH, tl ^ 8'h3c, "tbl_high");
    end
    $display("test table done");
    close_out();
  end
endmodule
